// ==== src/psrx_pkg.sv ====
// Constants and types shared by the primary serial receive block
package psrx_pkg;
  // ****************************************
  // Register map and reset values
  // ****************************************
  localparam logic [7:0] ADDR_TIMING  = 8'h26;
  localparam logic [7:0] ADDR_PINSEL  = 8'h27;
  localparam logic [7:0] ADDR_CH1     = 8'h28;
  localparam logic [7:0] ADDR_CH2     = 8'h29;
  localparam logic [7:0] RST_TIMING   = 8'h00;
  localparam logic [7:0] RST_PINSEL   = 8'h00;
  localparam logic [7:0] RST_CH1      = 8'h20;
  localparam logic [7:0] RST_CH2      = 8'h21;
  localparam logic [7:0] CH_LIVE_MASK = 8'h3f;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int EDGE_BIT    = 7;
  localparam int INTFS_BIT   = 6;
  localparam int INTBCLK_BIT = 5;
  localparam int CH_EN_BIT   = 5;
  localparam int FIELD_W     = 5;
  // ****************************************
  // Framing
  // ****************************************
  localparam int NUM_CH     = 2;
  localparam int SLOT_BITS  = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W     = SLOT_BITS + 1;
  localparam logic [4:0] LAST_BIT   = 5'h1f;
  localparam logic [5:0] I2S_LEAD   = 6'h01;
  localparam logic [5:0] PLAIN_LEAD = 6'h00;
  localparam logic [1:0] FMT_TDM    = 2'h0;
  localparam logic [1:0] FMT_I2S    = 2'h1;
  localparam logic [1:0] FMT_LJ     = 2'h2;
  localparam int CFG_W = 29;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_DATA} psrx_state_t;
endpackage

// ==== src/psrx_stream_if.sv ====
// Valid/ready word stream between the receive block and its buffer
`timescale 1ns/1ps
`default_nettype none
interface psrx_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== src/psrx_fifo.sv ====
// Synchronous word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module psrx_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic   clk,
  input wire logic   rstN,
  // Streams
  psrx_stream_if.snk inS,
  psrx_stream_if.src outS
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0]   count_q;
  logic          push;
  logic          pop;

  // Handshakes and honest flags
  assign inS.ready  = (count_q != (AW+1)'(DEPTH));
  assign outS.valid = (count_q != '0);
  assign outS.data  = mem[rdPtr_q];
  assign push = inS.valid && inS.ready;
  assign pop  = outS.valid && outS.ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inS.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== src/psrx_top.sv ====
// Primary serial port receive: timing, pin routing, slot capture
// Notes on behaviour
// RQ1: Edge select 0 samples data on the polarity edge, 1 on the opposite edge half a cycle later.
// RQ2: In controller mode the internal-frame-sync bit picks internal frame sync, else the pin.
// RQ3: In controller mode the internal-bit-clock bit picks internal bit clock, else the pin.
// RQ4: The 5-bit delay field moves the slot 0 MSB later by 0 to 31 bit clocks on both pins.
// RQ5: A delay of zero puts the MSB exactly where the standard format puts it.
// RQ6: In I2S and left-justified the delay applies to left and right slot 0, in TDM to slot 0.
// RQ7: Pin select bit n-1 takes channel n from the first pin when 0, second pin when 1.
// RQ8: Channel 1 enable bit 5 disables channel 1 when 0 and forwards it when 1, set at reset.
// RQ9: In TDM the 5-bit slot field picks slot n for n from 0 to 31.
// RQ10: In I2S or left-justified slot values 0-15 are left slots, 16-31 right slots 0-15.
// RQ11: Reserved channel bits 7-6 are written as zero by software and read back as zero.
// RQ12: Channel 2 enable works like channel 1, enabled at reset with default slot 1.
// RQ13: Disabled channels are ignored; enabled ones capture only their pin and slot.
`timescale 1ns/1ps
`default_nettype none
module psrx_top
  import psrx_pkg::*;
(
  // System clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  // Port mode
  input  wire logic        controllerMode,
  input  wire logic        bitClockPolarity,
  input  wire logic [1:0]  serialFormat,
  output logic             rxInternalBitClockSel,
  // Serial link
  input  wire logic        serialBitClk,
  input  wire logic        frameSync,
  input  wire logic        internalFrameSync,
  input  wire logic        firstSerialInputPin,
  input  wire logic        secondSerialInputPin,
  // Received words
  output logic             dacValid,
  output logic             dacChan,
  output logic [31:0]      dacData,
  input  wire logic        dacReady
);
  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] timing_q;
  logic [7:0] pinSel_q;
  logic [7:0] ch1Cfg_q;
  logic [7:0] ch2Cfg_q;
  logic [7:0] rdData_d;
  logic       useIntBclk_q;

  // Writes at printed offsets; reserved channel bits never stored
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timing_q <= RST_TIMING;
      pinSel_q <= RST_PINSEL;
      ch1Cfg_q <= RST_CH1; // RQ8
      ch2Cfg_q <= RST_CH2; // RQ12
    end else if (regWr) begin
      case (regAddr)
        ADDR_TIMING: timing_q <= regWrData;
        ADDR_PINSEL: pinSel_q <= regWrData;
        ADDR_CH1:    ch1Cfg_q <= regWrData & CH_LIVE_MASK; // RQ11
        ADDR_CH2:    ch2Cfg_q <= regWrData & CH_LIVE_MASK; // RQ11
        default:     ;
      endcase
    end
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    case (regAddr)
      ADDR_TIMING: rdData_d = timing_q;
      ADDR_PINSEL: rdData_d = pinSel_q;
      ADDR_CH1:    rdData_d = ch1Cfg_q & CH_LIVE_MASK; // RQ11
      ADDR_CH2:    rdData_d = ch2Cfg_q & CH_LIVE_MASK; // RQ11
      default:     rdData_d = 8'h00;
    endcase
  end

  // Registered read data and bit clock source select
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData    <= 8'h00;
      useIntBclk_q <= 1'b0;
    end else begin
      regRdData    <= rdData_d;
      useIntBclk_q <= controllerMode & timing_q[INTBCLK_BIT]; // RQ3
    end
  end
  assign rxInternalBitClockSel = useIntBclk_q;

  // ****************************************
  // Link domain: reset and settings crossing
  // ****************************************
  logic             linkRst1_q;
  logic             linkRstN;
  logic [CFG_W-1:0] cfgBus;
  logic [CFG_W-1:0] cfgS1_q;
  logic [CFG_W-1:0] cfgS2_q;

  // Reset release synchronised to the bit clock
  always_ff @(posedge serialBitClk or negedge nrst) begin
    if (!nrst) begin
      linkRst1_q <= 1'b0;
      linkRstN   <= 1'b0;
    end else begin
      linkRst1_q <= 1'b1;
      linkRstN   <= linkRst1_q;
    end
  end

  // Quasi-static settings, change only while the link is quiet
  // Spare bits keep each field at its unpacking position below
  assign cfgBus = {controllerMode, bitClockPolarity, serialFormat, 1'h0, timing_q, 2'h0,
                   pinSel_q[1:0], ch2Cfg_q[CH_EN_BIT:0], ch1Cfg_q[CH_EN_BIT:0]};
  always_ff @(posedge serialBitClk or negedge linkRstN) begin
    if (!linkRstN) begin
      cfgS1_q <= '0;
      cfgS2_q <= '0;
    end else begin
      cfgS1_q <= cfgBus;
      cfgS2_q <= cfgS1_q;
    end
  end

  logic                 ctrlS;
  logic                 polS;
  logic [1:0]           fmtS;
  logic                 edgeS;
  logic                 intFsS;
  logic [FIELD_W-1:0]   delayS;
  logic [NUM_CH-1:0]    pinS;
  logic [NUM_CH-1:0]    enS;
  logic [FIELD_W-1:0]   slotS [NUM_CH];
  assign ctrlS  = cfgS2_q[28];
  assign polS   = cfgS2_q[27];
  assign fmtS   = cfgS2_q[26:25];
  assign edgeS  = cfgS2_q[16+EDGE_BIT];
  assign intFsS = cfgS2_q[16+INTFS_BIT];
  assign delayS = cfgS2_q[16+FIELD_W-1:16];
  assign pinS   = cfgS2_q[13:12];
  assign enS    = {cfgS2_q[6+CH_EN_BIT], cfgS2_q[CH_EN_BIT]};
  assign slotS[0] = cfgS2_q[FIELD_W-1:0];
  assign slotS[1] = cfgS2_q[6+FIELD_W-1:6];

  // ****************************************
  // Link domain: sampling and framing
  // ****************************************
  logic [1:0]  dinNeg_q;
  logic [1:0]  bitIn;
  logic        fsSel;
  logic        fsPrev_q;
  logic        fsRise;
  logic        fsFall;
  logic        startEv;
  logic [5:0]  leadIn;
  psrx_state_t state_q;
  logic [5:0]  delayCnt_q;
  logic [4:0]  bitCnt_q;
  logic [4:0]  slot_q;
  logic        right_q;
  logic        shiftNow;
  logic        lastBit;
  logic [SLOT_BITS-1:0] shA_q;
  logic [SLOT_BITS-1:0] shB_q;
  logic [SLOT_BITS-1:0] wordA;
  logic [SLOT_BITS-1:0] wordB;
  logic [4:0]  slotCode;

  // Opposite-edge sample of both data pins
  always_ff @(negedge serialBitClk or negedge linkRstN) begin
    if (!linkRstN) begin
      dinNeg_q <= 2'h0;
    end else begin
      dinNeg_q <= {secondSerialInputPin, firstSerialInputPin};
    end
  end
  assign bitIn = (polS ^ edgeS) ? dinNeg_q
               : {secondSerialInputPin, firstSerialInputPin}; // RQ1

  // Frame sync source and half-frame starts
  assign fsSel   = (ctrlS && intFsS) ? internalFrameSync : frameSync; // RQ2
  assign fsRise  = fsSel && !fsPrev_q;
  assign fsFall  = !fsSel && fsPrev_q;
  assign startEv = fsRise || (fsFall && fmtS != FMT_TDM); // RQ6
  assign leadIn  = ((fmtS == FMT_I2S) ? I2S_LEAD : PLAIN_LEAD)
                 + {1'b0, delayS}; // RQ4 RQ5

  // A bit enters the shifters once the lead-in has run out
  always_comb begin
    if (startEv) begin
      shiftNow = (leadIn == 6'h00); // RQ5
    end else begin
      shiftNow = (state_q == ST_DATA)
              || (state_q == ST_DELAY && delayCnt_q == 6'h00); // RQ4
    end
  end
  assign lastBit = shiftNow && !startEv && bitCnt_q == LAST_BIT;
  assign wordA   = {shA_q[SLOT_BITS-2:0], bitIn[0]};
  assign wordB   = {shB_q[SLOT_BITS-2:0], bitIn[1]};
  assign slotCode = (fmtS == FMT_TDM) ? slot_q
                  : {right_q, slot_q[3:0]}; // RQ9 RQ10

  // Framing state, lead-in, bit and slot counters
  always_ff @(posedge serialBitClk or negedge linkRstN) begin
    if (!linkRstN) begin
      fsPrev_q   <= 1'b0;
      state_q    <= ST_IDLE;
      delayCnt_q <= 6'h00;
      bitCnt_q   <= 5'h00;
      slot_q     <= 5'h00;
      right_q    <= 1'b0;
    end else begin
      fsPrev_q <= fsSel;
      if (startEv) begin
        right_q    <= fsFall; // RQ6
        slot_q     <= 5'h00;
        bitCnt_q   <= shiftNow ? 5'h01 : 5'h00;
        delayCnt_q <= shiftNow ? 6'h00 : leadIn - 6'h01;
        state_q    <= shiftNow ? ST_DATA : ST_DELAY;
      end else begin
        case (state_q)
          ST_DELAY: begin
            if (shiftNow) begin
              state_q  <= ST_DATA;
              bitCnt_q <= 5'h01;
            end else begin
              delayCnt_q <= delayCnt_q - 6'h01;
            end
          end
          ST_DATA: begin
            bitCnt_q <= bitCnt_q + 5'h01;
            if (lastBit) begin
              slot_q <= slot_q + 5'h01;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Serial shifters for both pins
  always_ff @(posedge serialBitClk or negedge linkRstN) begin
    if (!linkRstN) begin
      shA_q <= '0;
      shB_q <= '0;
    end else if (shiftNow) begin
      shA_q <= wordA;
      shB_q <= wordB;
    end
  end

  // ****************************************
  // Link domain: per-channel capture and hand-off
  // ****************************************
  logic [NUM_CH-1:0]    pend_q;
  logic [NUM_CH-1:0]    hit;
  logic [NUM_CH-1:0]    take;
  logic [SLOT_BITS-1:0] chData_q [NUM_CH];
  logic                 reqTgl_q;
  logic                 ackS1_q;
  logic                 ackS2_q;
  logic                 ackTgl_q;
  logic                 linkBusy;
  logic [WORD_W-1:0]    xfer_q;

  assign linkBusy = (reqTgl_q != ackS2_q);
  assign take[0]  = !linkBusy && pend_q[0];
  assign take[1]  = !linkBusy && pend_q[1] && !pend_q[0];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    // Enabled channel, its slot and a legal half-frame position
    assign hit[c] = lastBit && enS[c] && slotCode == slotS[c]
                 && (fmtS == FMT_TDM || !slot_q[4]); // RQ13

    // Word capture; a new word wins over the hand-off clear
    always_ff @(posedge serialBitClk or negedge linkRstN) begin
      if (!linkRstN) begin
        pend_q[c]   <= 1'b0;
        chData_q[c] <= '0;
      end else if (hit[c]) begin
        pend_q[c]   <= 1'b1; // RQ8 RQ12
        chData_q[c] <= pinS[c] ? wordB : wordA; // RQ7
      end else if (take[c]) begin
        pend_q[c]   <= 1'b0;
      end
    end
  end

  // Toggle handshake launching one word at a time
  always_ff @(posedge serialBitClk or negedge linkRstN) begin
    if (!linkRstN) begin
      reqTgl_q <= 1'b0;
      ackS1_q  <= 1'b0;
      ackS2_q  <= 1'b0;
      xfer_q   <= '0;
    end else begin
      ackS1_q <= ackTgl_q;
      ackS2_q <= ackS1_q;
      if (take[0] || take[1]) begin
        xfer_q   <= {take[1], take[1] ? chData_q[1] : chData_q[0]};
        reqTgl_q <= !reqTgl_q;
      end
    end
  end

  // ****************************************
  // System domain: buffer and output stage
  // ****************************************
  logic reqS1_q;
  logic reqS2_q;
  psrx_stream_if #(.W(WORD_W)) fifoIn ();
  psrx_stream_if #(.W(WORD_W)) fifoOut ();

  // Word is stable while the request is outstanding
  assign fifoIn.valid  = (reqS2_q != ackTgl_q);
  assign fifoIn.data   = xfer_q;
  assign fifoOut.ready = !dacValid || dacReady;

  // Request sync and acknowledge once the buffer takes the word
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reqS1_q  <= 1'b0;
      reqS2_q  <= 1'b0;
      ackTgl_q <= 1'b0;
    end else begin
      reqS1_q <= reqTgl_q;
      reqS2_q <= reqS1_q;
      if (fifoIn.valid && fifoIn.ready) begin
        ackTgl_q <= !ackTgl_q;
      end
    end
  end

  psrx_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk  (ref_clk),
    .rstN (nrst),
    .inS  (fifoIn),
    .outS (fifoOut)
  );

  // Registered word output towards the DAC path
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dacValid <= 1'b0;
      dacChan  <= 1'b0;
      dacData  <= '0;
    end else if (fifoOut.ready) begin
      dacValid <= fifoOut.valid;
      dacChan  <= fifoOut.data[SLOT_BITS];
      dacData  <= fifoOut.data[SLOT_BITS-1:0];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_chWrite;
    regWr && regAddr == ADDR_CH1;
  endsequence

  a_rsvd_reads_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ11
    (regAddr == ADDR_CH1 || regAddr == ADDR_CH2) |=> regRdData[7:6] == 2'h0)
    else $error("reserved channel bits read nonzero");
  a_ch1_enable_store: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ8
    s_chWrite ##1 regAddr == ADDR_CH1 |=> regRdData[CH_EN_BIT] == $past(regWrData[CH_EN_BIT], 2))
    else $error("channel 1 enable not stored");
  a_ch2_reset_val: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ12
    $rose(nrst) |-> ch2Cfg_q == RST_CH2)
    else $error("channel 2 reset value wrong");
  a_int_bclk_sel: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ3
    regWr && regAddr == ADDR_TIMING && controllerMode ##1 controllerMode
    |=> rxInternalBitClockSel == $past(regWrData[INTBCLK_BIT], 2))
    else $error("bit clock select wrong");
  a_zero_delay_msb: assert property (@(posedge serialBitClk) disable iff (!linkRstN) // RQ5
    startEv && fmtS == FMT_LJ && delayS == 5'h00 |-> shiftNow)
    else $error("zero delay did not capture msb");
  a_delay_two_bits: assert property (@(posedge serialBitClk) disable iff (!linkRstN) // RQ4
    startEv && leadIn == 6'h02 ##1 !startEv[*3] |-> state_q == ST_DATA && bitCnt_q == 5'h01)
    else $error("lead-in length wrong");
  a_lead_in_len: assert property (@(posedge serialBitClk) disable iff (!linkRstN) // RQ4
    startEv && leadIn == 6'h02 ##1 !startEv ##1 !startEv |-> $past(!shiftNow) && shiftNow)
    else $error("msb delay not two bit clocks");
  a_int_frame_sync_start: assert property (@(posedge serialBitClk) disable iff (!linkRstN) // RQ2
    ctrlS && intFsS && internalFrameSync && !fsPrev_q |-> startEv)
    else $error("internal frame sync not used");
  a_right_half: assert property (@(posedge serialBitClk) disable iff (!linkRstN) // RQ6
    fsFall && fmtS != FMT_TDM |=> right_q && state_q != ST_IDLE)
    else $error("right half not started");
  a_edge_sample: assert property (@(posedge serialBitClk) disable iff (!linkRstN) // RQ1
    shiftNow && !polS && !edgeS |=> shA_q[0] == $past(firstSerialInputPin))
    else $error("wrong capture edge");
  a_disabled_drop: assert property (@(posedge serialBitClk) disable iff (!linkRstN) // RQ13
    lastBit && !enS[0] && !pend_q[0] |=> !pend_q[0])
    else $error("disabled channel captured");
  a_slot_pin_hit: assert property (@(posedge serialBitClk) disable iff (!linkRstN) // RQ7 RQ9
    lastBit && enS[0] && pinS[0] && fmtS == FMT_TDM && slot_q == slotS[0]
    |=> pend_q[0] && chData_q[0] == $past(wordB))
    else $error("slot or pin routing wrong");
  a_i2s_right_slot: assert property (@(posedge serialBitClk) disable iff (!linkRstN) // RQ10
    lastBit && enS[0] && fmtS == FMT_I2S && right_q && !slot_q[4]
    && slotS[0] == {1'b1, slot_q[3:0]} |=> pend_q[0])
    else $error("right slot not captured");
endmodule
`default_nettype wire

// ==== tb/psrx_host.sv ====
// Far-side serial source: bit clock, frame syncs and two data pins
`timescale 1ns/1ps
`default_nettype none
module psrx_host (
  // Link clock and frame syncs
  output logic bclk,
  output logic fsExt,
  output logic fsInt,
  // Serial data pins
  output logic din1,
  output logic second_serial_input_pin
);
  // ****************************************
  // Slot words and framing
  // ****************************************
  logic [31:0] w [2][2][32]; // Pin, half, slot
  logic        sh;           // Data held over the falling edge
  logic        useInt;       // Frame sync sent on the internal line
  // Idle levels, clock stopped low
  initial begin
    {bclk, fsExt, fsInt, din1, second_serial_input_pin} = 5'h00;
    sh = 1'b0;
    useInt = 1'b0;
  end
  // One bit clock; data inverts each half so only one edge sees it
  task automatic cyc(input logic f, input logic b1, input logic b2);
    bclk = 1'b1;
    #1;
    if (useInt) fsInt = f;
    else fsExt = f;
    din1 = b1 ^ ~sh;
    second_serial_input_pin = b2 ^ ~sh;
    #79 bclk = 1'b0;
    #1;
    din1 = ~din1;
    second_serial_input_pin = ~second_serial_input_pin;
    #79;
  endtask
  // Bit of a half, toggling filler until the lead-in ends
  function automatic logic bitAt(input int pin, input int h, input int p, input int ld);
    int j;
    j = p - ld;
    if (p < ld) return p[0];
    return w[pin][h][j / 32][31 - j % 32];
  endfunction
  // Clocks with frame sync low
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 1'b1);
  endtask
  // Settle clocks, one or two halves, flush clocks; then the clock stops
  task automatic frame(input logic tdm, input int ld, input int nSl);
    idle(5);
    for (int h = 0; h < (tdm ? 1 : 2); h++) begin
      for (int p = 0; p < ld + 32 * nSl; p++) begin
        cyc(tdm ? p == 0 : h == 0, bitAt(0, h, p, ld), bitAt(1, h, p, ld));
      end
    end
    idle(8);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_psrx_top.sv ====
// Testbench for the primary serial receive block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_psrx_top;
  import psrx_pkg::*;
  // ****************************************
  // Signals and case table
  // ****************************************
  logic        ref_clk, nrst, regWr, controllerMode, bitClockPolarity;
  logic [7:0]  regAddr, regWrData, regRdData;
  logic [1:0]  serialFormat;
  logic        rxInternalBitClockSel, serialBitClk, frameSync, internalFrameSync;
  logic        firstSerialInputPin, secondSerialInputPin, dacValid, dacChan, dacReady;
  logic [31:0] dacData;
  int          err_count, compares;
  logic        hold;
  logic [15:0] ws = 16'h8b9e;
  logic [15:0] rs = 16'h8b9e;
  logic [32:0] expQ [$];
  logic [7:0]  cTim [7] = '{8'h00, 8'h1f, 8'h85, 8'he0, 8'h03, 8'h40, 8'h42};
  logic [7:0]  cPin [7] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h00, 8'h02, 8'h03};
  logic [7:0]  cC1  [7] = '{8'h20, 8'h23, 8'h00, 8'h21, 8'h30, 8'h31, 8'h3f};
  logic [7:0]  cC2  [7] = '{8'h21, 8'h22, 8'h20, 8'h21, 8'h21, 8'h20, 8'h00};
  logic [1:0]  cFmt [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
  logic        cPol [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic        cCm  [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  psrx_top i_psrx_top (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWr(regWr),
    .regWrData(regWrData), .regRdData(regRdData), .controllerMode(controllerMode),
    .bitClockPolarity(bitClockPolarity), .serialFormat(serialFormat),
    .rxInternalBitClockSel(rxInternalBitClockSel), .serialBitClk(serialBitClk),
    .frameSync(frameSync), .internalFrameSync(internalFrameSync),
    .firstSerialInputPin(firstSerialInputPin), .secondSerialInputPin(secondSerialInputPin),
    .dacValid(dacValid), .dacChan(dacChan), .dacData(dacData), .dacReady(dacReady));
  psrx_host i_host (.bclk(serialBitClk), .fsExt(frameSync), .fsInt(internalFrameSync),
    .din1(firstSerialInputPin), .second_serial_input_pin(secondSerialInputPin));
  // ****************************************
  // Clock, readiness and result monitor
  // ****************************************
  always #4 ref_clk = ~ref_clk;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] rnd32();
    logic [15:0] lo;
    ws = nx(ws);
    lo = ws;
    ws = nx(ws);
    return {ws, lo};
  endfunction
  // Random consumer stalls, held off while the buffer fills
  always @(posedge ref_clk) begin
    #1;
    rs = nx(rs);
    dacReady = ~hold & rs[0];
  end
  // Each accepted word against the model queue
  always @(posedge ref_clk) begin
    logic [32:0] e;
    if (nrst === 1'b1 && dacValid === 1'b1 && dacReady === 1'b1) begin
      `CHK(expQ.size() > 0, 1'b1)
      if (expQ.size() > 0) begin
        e = expQ.pop_front();
        `CHK({dacChan, dacData}, e)
      end
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regWr = 1'b1;
    regWrData = d;
    @(posedge ref_clk);
    #1;
    regWr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    @(posedge ref_clk);
    #1;
    `CHK(regRdData, x)
  endtask
  // Wait for all expected words, then watch for strays
  task automatic drain();
    for (int i = 0; i < 500 && expQ.size() > 0; i++) @(posedge ref_clk);
    if (expQ.size() > 0) begin
      err_count++;
      $display("[ERR] %0t words missing", $time);
      expQ.delete();
    end
    repeat (20) @(posedge ref_clk);
  endtask
  // One configuration, nFr frames, words checked in arrival order
  task automatic run(input int k, input int nFr);
    logic [7:0] c [2];
    int         sl [2];
    int         key [2];
    int         nSl;
    logic       tdm;
    c[0] = cC1[k];
    c[1] = cC2[k];
    tdm = cFmt[k] == FMT_TDM;
    wr(ADDR_TIMING, cTim[k]);
    wr(ADDR_PINSEL, cPin[k]);
    wr(ADDR_CH1, c[0]);
    wr(ADDR_CH2, c[1]);
    serialFormat = cFmt[k];
    bitClockPolarity = cPol[k];
    controllerMode = cCm[k];
    rd(ADDR_TIMING, cTim[k]);
    rd(ADDR_CH1, c[0]);
    `CHK(rxInternalBitClockSel, cCm[k] & cTim[k][5])
    nSl = 1;
    for (int i = 0; i < 2; i++) begin
      sl[i] = tdm ? int'(c[i][4:0]) : int'(c[i][3:0]);
      key[i] = (tdm ? 0 : 64 * c[i][4]) + 2 * sl[i] + i;
      if (c[i][5] && sl[i] >= nSl) nSl = sl[i] + 1;
    end
    i_host.sh = cPol[k] ^ cTim[k][7];
    i_host.useInt = cCm[k] & cTim[k][6];
    if (nFr > 1) begin
      @(negedge ref_clk);
      hold = 1'b1;
    end
    for (int f = 0; f < nFr; f++) begin
      foreach (i_host.w[p, h, s]) i_host.w[p][h][s] = rnd32();
      for (int j = 0; j < 2; j++) begin
        int i;
        i = (key[1] < key[0]) ? 1 - j : j;
        if (c[i][5]) expQ.push_back({i[0], i_host.w[cPin[k][i]][tdm ? 0 : c[i][4]][sl[i]]});
      end
      i_host.frame(tdm, int'(cTim[k][4:0]) + (cFmt[k] == FMT_I2S), nSl);
    end
    if (nFr > 1) begin
      `CHK(dacValid, 1'b1)
      @(negedge ref_clk);
      hold = 1'b0;
    end
    drain();
    $display("test %0d done", k);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {ref_clk, regWr, controllerMode, bitClockPolarity, hold, nrst} = 6'h00;
    regAddr = 8'h00;
    regWrData = 8'h00;
    serialFormat = 2'h0;
    err_count = 0;
    compares = 0;
    fork
      i_host.idle(3);
      repeat (3) @(posedge ref_clk);
    join
    @(posedge ref_clk);
    #1 nrst = 1'b1;
    rd(ADDR_TIMING, RST_TIMING);
    rd(ADDR_PINSEL, RST_PINSEL);
    rd(ADDR_CH1, RST_CH1);
    rd(ADDR_CH2, RST_CH2);
    wr(8'h2a, 8'hff);
    rd(8'h2a, 8'h00);
    wr(ADDR_CH1, 8'h05);
    rd(ADDR_CH1, 8'h05);
    for (int k = 0; k < 7; k++) run(k, 1);
    run(0, 5);
    give_verdict();
  end
endmodule
`default_nettype wire
